// >>> rtl/srcr_config_bank.sv
// Switch route configuration register bank with decoded route outputs
// Functional notes
// RQ1 - Fast enable 0: channels off, standby
// RQ2 - Fast bundle 00 quad, 01 dual, 10 single
// RQ3 - Fast bundle write 11 ignored, field held
// RQ4 - Quad: low select bits pick source
// RQ5 - Dual: bits 2:1 source, bit0 pair
// RQ6 - Single: four bits pick one channel
// RQ7 - Side enable 0 breaks all side connections
// RQ8 - Side bundle 11 illegal, field held
// RQ9 - Side quad: low bits pick source
// RQ10 - Input termination bit 0 switches off
// RQ11 - Reset loads defaults, routes follow immediately
`timescale 1ns/1ps
`include "srcr_defines.svh"
module srcr_config_bank (
  input wire logic CLK, // 40 MHz clock
  input wire logic RST, // Async reset, active high
  input wire logic CE, // Clock enable
  input wire logic WR, // Register write strobe
  input wire logic RD, // Register read strobe
  input wire logic [7:0] ADDR, // Register offset
  input wire logic [7:0] WDATA, // Write data
  output logic [7:0] RDATA, // Read data
  output logic RVALID, // Read data valid, one cycle after RD
  output logic FAST_PATH_ON, // Fast channels active
  output logic STANDBY, // Low power standby
  output logic [1:0] FAST_BUNDLE, // Fast bundle mode
  output logic [15:0] FAST_OUT_SEL, // Channel index per output, 4 bits each
  output logic SIDE_ON, // Side switch connected
  output logic [1:0] SIDE_BUNDLE, // Side bundle mode
  output logic [15:0] SIDE_OUT_SEL, // Side channel index per common line
  output logic IN_TERM_ON, // Input termination on
  output logic [15:0] TERM_PULSE_SEL, // Per channel termination pulse
  output logic [15:0] EQ_LEVEL_SEL, // Equalizer levels
  output logic [1:0] PREEMPH_LEVEL, // Output pre-emphasis
  output logic OUT_TERM_SEL, // Output termination select
  output logic OUT_CURRENT_SEL // Output current level
);
  typedef struct packed {
    logic [7:0] fast_modes_reg;
    logic [7:0] side_modes_reg;
    logic [7:0] rx_set_reg;
    logic [7:0] term_ab_reg;
    logic [7:0] term_cd_reg;
    logic [7:0] eq_ab_reg;
    logic [7:0] eq_cd_reg;
    logic [7:0] tx_set_reg;
    logic [15:0] fast_sel_reg;
    logic [15:0] side_sel_reg;
  } srcr_state_t;

  srcr_state_t st_reg, st_next;
  logic [7:0] rd_mux;
  srcr_route_if fast_rt ();
  srcr_route_if side_rt ();

  ////////////////////////////////////////////////////////////////////////////
  // Route decoders
  assign fast_rt.enable = st_next.fast_modes_reg[`SRCR_BIT_EN];
  assign fast_rt.bundle = st_next.fast_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO];
  assign fast_rt.source = st_next.fast_modes_reg[`SRCR_SRC_HI:`SRCR_SRC_LO];
  assign side_rt.enable = st_next.side_modes_reg[`SRCR_BIT_EN];
  assign side_rt.bundle = st_next.side_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO];
  assign side_rt.source = st_next.side_modes_reg[`SRCR_SRC_HI:`SRCR_SRC_LO];

  srcr_route_dec u_fast_dec (
    .rt(fast_rt.dec)
  );
  srcr_route_dec u_side_dec (
    .rt(side_rt.dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_comb begin
    st_next = st_reg;
    if (WR) begin
      unique case (ADDR)
        `SRCR_OFF_FAST_MODES: begin
          st_next.fast_modes_reg = {1'b0, WDATA[6:0]};
          if (WDATA[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO] == `SRCR_BUNDLE_ILLEGAL) begin
            // Illegal bundle code: keep prior field only
            st_next.fast_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO] =
              st_reg.fast_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO]; // RQ3
          end
        end
        `SRCR_OFF_SIDE_MODES: begin
          st_next.side_modes_reg = {1'b0, WDATA[6:0]};
          if (WDATA[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO] == `SRCR_BUNDLE_ILLEGAL) begin
            st_next.side_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO] =
              st_reg.side_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO]; // RQ8
          end
        end
        `SRCR_OFF_RX_SET: st_next.rx_set_reg = {7'h00, WDATA[`SRCR_BIT_TERM_ON]};
        `SRCR_OFF_TERM_AB: st_next.term_ab_reg = WDATA;
        `SRCR_OFF_TERM_CD: st_next.term_cd_reg = WDATA;
        `SRCR_OFF_EQ_AB: st_next.eq_ab_reg = WDATA;
        `SRCR_OFF_EQ_CD: st_next.eq_cd_reg = WDATA;
        `SRCR_OFF_TX_SET: st_next.tx_set_reg = {4'h0, WDATA[3:0]};
        default: begin
        end
      endcase
    end
    // Disabled switch drives no selection
    st_next.fast_sel_reg = fast_rt.enable ? fast_rt.pick : 16'h0000; // RQ1 RQ2
    st_next.side_sel_reg = side_rt.enable ? side_rt.pick : 16'h0000; // RQ7
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      // Defaults; selections match the default quad source A routing
      st_reg <= '{fast_modes_reg: `SRCR_RST_MODES, side_modes_reg: `SRCR_RST_MODES,
                  rx_set_reg: `SRCR_RST_RX_SET, term_ab_reg: `SRCR_RST_TERM,
                  term_cd_reg: `SRCR_RST_TERM, eq_ab_reg: `SRCR_RST_EQ,
                  eq_cd_reg: `SRCR_RST_EQ, tx_set_reg: `SRCR_RST_TX_SET,
                  fast_sel_reg: `SRCR_RST_SEL, side_sel_reg: `SRCR_RST_SEL}; // RQ11
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back
  always_comb begin
    unique case (ADDR)
      `SRCR_OFF_FAST_MODES: rd_mux = st_reg.fast_modes_reg;
      `SRCR_OFF_SIDE_MODES: rd_mux = st_reg.side_modes_reg;
      `SRCR_OFF_RX_SET: rd_mux = st_reg.rx_set_reg;
      `SRCR_OFF_TERM_AB: rd_mux = st_reg.term_ab_reg;
      `SRCR_OFF_TERM_CD: rd_mux = st_reg.term_cd_reg;
      `SRCR_OFF_EQ_AB: rd_mux = st_reg.eq_ab_reg;
      `SRCR_OFF_EQ_CD: rd_mux = st_reg.eq_cd_reg;
      `SRCR_OFF_TX_SET: rd_mux = st_reg.tx_set_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  srcr_read_port u_rd (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .rd(RD),
    .mux(rd_mux),
    .rdata(RDATA),
    .rvalid(RVALID)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign FAST_PATH_ON = st_reg.fast_modes_reg[`SRCR_BIT_EN]; // RQ1
  assign STANDBY = ~st_reg.fast_modes_reg[`SRCR_BIT_EN]; // RQ1
  assign FAST_BUNDLE = st_reg.fast_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO]; // RQ2
  assign FAST_OUT_SEL = st_reg.fast_sel_reg;
  assign SIDE_ON = st_reg.side_modes_reg[`SRCR_BIT_EN]; // RQ7
  assign SIDE_BUNDLE = st_reg.side_modes_reg[`SRCR_BUNDLE_HI:`SRCR_BUNDLE_LO];
  assign SIDE_OUT_SEL = st_reg.side_sel_reg;
  assign IN_TERM_ON = st_reg.rx_set_reg[`SRCR_BIT_TERM_ON]; // RQ10
  // Pulse select taken straight from the term registers, not gated by termination on
  assign TERM_PULSE_SEL = {st_reg.term_cd_reg, st_reg.term_ab_reg};
  assign EQ_LEVEL_SEL = {st_reg.eq_cd_reg, st_reg.eq_ab_reg};
  assign PREEMPH_LEVEL = st_reg.tx_set_reg[`SRCR_PREEMPH_LEVEL_HI:`SRCR_PREEMPH_LEVEL_LO];
  assign OUT_TERM_SEL = st_reg.tx_set_reg[`SRCR_BIT_OUT_TERM];
  assign OUT_CURRENT_SEL = st_reg.tx_set_reg[`SRCR_BIT_OUT_CUR];
endmodule

// >>> rtl/srcr_defines.svh
// Register map, field positions and reset values of the route configuration bank
`ifndef SRCR_DEFINES_SVH
`define SRCR_DEFINES_SVH
`define SRCR_OFF_FAST_MODES 8'h00
`define SRCR_OFF_SIDE_MODES 8'h01
`define SRCR_OFF_RX_SET 8'h10
`define SRCR_OFF_TERM_AB 8'h11
`define SRCR_OFF_TERM_CD 8'h12
`define SRCR_OFF_EQ_AB 8'h13
`define SRCR_OFF_EQ_CD 8'h14
`define SRCR_OFF_TX_SET 8'h20
`define SRCR_RST_MODES 8'h40
`define SRCR_RST_RX_SET 8'h01
`define SRCR_RST_TERM 8'h00
`define SRCR_RST_EQ 8'h00
`define SRCR_RST_TX_SET 8'h03
`define SRCR_RST_SEL 16'h3210
`define SRCR_BIT_EN 6
`define SRCR_BUNDLE_HI 5
`define SRCR_BUNDLE_LO 4
`define SRCR_SRC_HI 3
`define SRCR_SRC_LO 0
`define SRCR_BIT_TERM_ON 0
`define SRCR_PREEMPH_LEVEL_HI 3
`define SRCR_PREEMPH_LEVEL_LO 2
`define SRCR_BIT_OUT_TERM 1
`define SRCR_BIT_OUT_CUR 0
`define SRCR_BUNDLE_ILLEGAL 2'h3
`define SRCR_READ_LAT 1
`endif

// >>> rtl/srcr_pkg.sv
// Types shared by the route configuration bank
package srcr_pkg;
  typedef enum logic [1:0] {
    SRCR_QUAD = 2'h0,
    SRCR_DUAL = 2'h1,
    SRCR_SINGLE = 2'h2
  } srcr_bundle_t;
  typedef struct packed {
    logic [7:0] rdata_reg;
    logic rvalid_reg;
  } srcr_rd_state_t;
endpackage

// >>> rtl/srcr_read_port.sv
// Registered read data stage of the configuration bank
`timescale 1ns/1ps
module srcr_read_port (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset
  input wire logic ce, // Clock enable
  input wire logic rd, // Read strobe
  input wire logic [7:0] mux, // Selected register value
  output logic [7:0] rdata, // Read data
  output logic rvalid // Read data valid
);
  srcr_pkg::srcr_rd_state_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.rvalid_reg = rd;
    if (rd) begin
      s_next.rdata_reg = mux;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign rdata = s_reg.rdata_reg;
  assign rvalid = s_reg.rvalid_reg;
endmodule

// >>> rtl/srcr_route_dec.sv
// Route decoder: bundle mode and source select to per-output channel index
`timescale 1ns/1ps
`include "srcr_defines.svh"
module srcr_route_dec (
  srcr_route_if.dec rt // Route selection
);
  always_comb begin
    for (int o = 0; o < 4; o++) begin
      unique case (rt.bundle)
        srcr_pkg::SRCR_DUAL: begin
          // Pair: even channel to outputs 1:0, odd to 3:2
          rt.pick[o] = {rt.source[2:1], rt.source[0], o[1]}; // RQ5
        end
        srcr_pkg::SRCR_SINGLE: begin
          rt.pick[o] = rt.source; // RQ6
        end
        default: begin
          // Quad and held codes: low two source bits, channel o to output o
          rt.pick[o] = {rt.source[1:0], o[1:0]}; // RQ4 RQ9
        end
      endcase
    end
  end
endmodule

// >>> rtl/srcr_route_if.sv
// Route selection carried from the bank to the route decoder, decoded channel picks carried back
`timescale 1ns/1ps
interface srcr_route_if;
  logic enable;
  logic [1:0] bundle;
  logic [3:0] source;
  logic [3:0][3:0] pick;
  modport cfg (output enable, output bundle, output source, input pick);
  modport dec (input enable, input bundle, input source, output pick);
endinterface

// >>> test/srcr_cfg_monitor.sv
// Checker on the route bank ports
`timescale 1ns/1ps
module srcr_cfg_monitor (
  input wire logic CLK, // Clock
  input wire logic RST, // Reset
  input wire logic CE, // Enable
  input wire logic WR, // Write
  input wire logic [7:0] ADDR, // Offset
  input wire logic [7:0] WDATA, // Data
  input wire logic FAST_PATH_ON, // Fast on
  input wire logic STANDBY, // Standby
  input wire logic [1:0] FAST_BUNDLE, // Fast mode
  input wire logic [15:0] FAST_OUT_SEL, // Routes
  input wire logic SIDE_ON, // Side on
  input wire logic IN_TERM_ON // Termination
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  wire logic wm = CE && WR && ADDR == 8'h00;
  AST_STBY: assert property (STANDBY == !FAST_PATH_ON)
    else $error("standby mismatch");
  AST_EN: assert property (wm |=> FAST_PATH_ON == $past(WDATA[6]))
    else $error("fast enable wrong");
  AST_OFF: assert property (!FAST_PATH_ON |-> FAST_OUT_SEL == 16'h0000)
    else $error("route while off");
  AST_MODE_SET: assert property (wm && WDATA[5:4] != 2'h3 |=> FAST_BUNDLE == $past(WDATA[5:4]))
    else $error("bundle not set");
  AST_MODE_OK: assert property (FAST_BUNDLE != 2'h3)
    else $error("bundle illegal");
  AST_MODE_HOLD: assert property (wm && WDATA[5:4] == 2'h3 |=> $stable(FAST_BUNDLE))
    else $error("bundle not held");
  AST_QUAD: assert property (wm && WDATA[6:4] == 3'h4 |=> FAST_OUT_SEL ==
    {$past(WDATA[1:0]), 2'h3, $past(WDATA[1:0]), 2'h2, $past(WDATA[1:0]), 2'h1, $past(WDATA[1:0]), 2'h0})
    else $error("quad route wrong");
  AST_SIDE: assert property (CE && WR && ADDR == 8'h01 |=> SIDE_ON == $past(WDATA[6]))
    else $error("side enable wrong");
  AST_TERM: assert property (CE && WR && ADDR == 8'h10 |=> IN_TERM_ON == $past(WDATA[0]))
    else $error("termination wrong");
  cover property (wm && WDATA[5:4] == 2'h3);
  cover property (FAST_PATH_ON && FAST_BUNDLE == 2'h1);
  cover property (FAST_PATH_ON && FAST_BUNDLE == 2'h2);
endmodule
bind srcr_config_bank srcr_cfg_monitor mon_u (.*);

// >>> test/srcr_host_model.sv
// Host model issuing register cycles
`timescale 1ns/1ps
module srcr_host_model (
  input wire logic CLK, // Clock
  output logic CE, // Enable
  output logic WR, // Write
  output logic RD, // Read
  output logic [7:0] ADDR, // Offset
  output logic [7:0] WDATA, // Data
  input wire logic [7:0] RDATA, // Read data
  input wire logic RVALID // Read valid
);
  initial begin
    CE = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h5A;
    WDATA = 8'hA5;
  end
  // Clock enable level for the following cycles
  task automatic set_ce(input logic e);
    CE = e;
  endtask
  // Released lines show inverted values; one idle cycle closes each call
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    WR = 1'b1;
    ADDR = a;
    WDATA = d;
    @(posedge CLK);
    #2;
    WR = 1'b0;
    ADDR = ~a;
    WDATA = ~d;
    @(posedge CLK);
    #2;
  endtask
  // Read data stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    RD = 1'b1;
    ADDR = a;
    @(posedge CLK);
    #2;
    RD = 1'b0;
    ADDR = ~a;
    v = RVALID;
    d = RDATA;
    @(posedge CLK);
    #2;
  endtask
endmodule

// >>> test/tb_top.sv
// Testbench for the route configuration bank
`timescale 1ns/1ps
module tb_top;
  logic CLK, RST, CE, WR, RD, RVALID, FAST_PATH_ON, STANDBY, SIDE_ON, IN_TERM_ON, OUT_TERM_SEL, OUT_CURRENT_SEL;
  logic [7:0] ADDR, WDATA, RDATA, got;
  logic [1:0] FAST_BUNDLE, SIDE_BUNDLE, PREEMPH_LEVEL;
  logic [15:0] FAST_OUT_SEL, SIDE_OUT_SEL, TERM_PULSE_SEL, EQ_LEVEL_SEL;
  logic vld;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] ra [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  logic [7:0] rv [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [7:0] mw [5] = '{8'h4E, 8'h5B, 8'h6D, 8'h71, 8'hAD};
  logic [15:0] me [5] = '{16'hBA98, 16'h7766, 16'hDDDD, 16'h1111, 16'h0000};
  logic [1:0] mb [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
  srcr_config_bank dut_u (.*);
  srcr_host_model host_u (.*);
  initial CLK = 1'b0;
  always #12.5 CLK = ~CLK;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, got, vld);
    chk({7'h00, vld, got}, {8'h01, e});
  endtask
  task automatic close_out;
    $display("errors=%0d checks=%0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    RST = 1'b1;
    repeat (6) @(posedge CLK);
    #2;
    RST = 1'b0;
    chk(FAST_OUT_SEL, 16'h3210);
    chk(SIDE_OUT_SEL, 16'h3210);
    chk(TERM_PULSE_SEL, 16'h0000);
    chk(EQ_LEVEL_SEL, 16'h0000);
    chk({12'h0, PREEMPH_LEVEL, OUT_TERM_SEL, OUT_CURRENT_SEL}, 16'h0003);
    chk({13'h0, FAST_PATH_ON, SIDE_ON, IN_TERM_ON}, 16'h0007);
    for (int i = 0; i < 8; i++) rdc(ra[i], rv[i]);
    for (int i = 0; i < 5; i++) begin
      host_u.wr(8'h00, mw[i]);
      chk({14'h0, FAST_BUNDLE}, {14'h0, mb[i]});
      chk(FAST_OUT_SEL, me[i]);
      chk({15'h0, STANDBY}, {15'h0, ~mw[i][6]});
      chk({15'h0, FAST_PATH_ON}, {15'h0, mw[i][6]});
    end
    rdc(8'h00, 8'h2D);
    host_u.set_ce(1'b0);
    host_u.wr(8'h00, 8'h40);
    chk({14'h0, FAST_BUNDLE}, 16'h0002);
    chk(FAST_OUT_SEL, 16'h0000);
    host_u.set_ce(1'b1);
    host_u.wr(8'h01, 8'h00);
    chk({SIDE_ON, 15'h0}, 16'h0000);
    chk(SIDE_OUT_SEL, 16'h0000);
    host_u.wr(8'h01, 8'h73);
    chk({14'h0, SIDE_BUNDLE}, 16'h0000);
    chk(SIDE_OUT_SEL, 16'hFEDC);
    host_u.wr(8'h01, 8'h6B);
    chk({14'h0, SIDE_BUNDLE}, 16'h0002);
    chk(SIDE_OUT_SEL, 16'hBBBB);
    host_u.wr(8'h10, 8'hFE);
    chk({15'h0, IN_TERM_ON}, 16'h0000);
    rdc(8'h10, 8'h00);
    host_u.wr(8'h10, 8'h01);
    chk({15'h0, IN_TERM_ON}, 16'h0001);
    host_u.wr(8'h11, 8'hA5);
    host_u.wr(8'h12, 8'h3C);
    chk(TERM_PULSE_SEL, 16'h3CA5);
    host_u.wr(8'h13, 8'h96);
    host_u.wr(8'h14, 8'h69);
    chk(EQ_LEVEL_SEL, 16'h6996);
    host_u.wr(8'h20, 8'hF6);
    chk({12'h0, PREEMPH_LEVEL, OUT_TERM_SEL, OUT_CURRENT_SEL}, 16'h0006);
    rdc(8'h20, 8'h06);
    rdc(8'h05, 8'h00);
    close_out();
  end
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule
